// ===== src/pcfr_regs.sv
`timescale 1ns/10ps
module pcfr_regs import pcfr_pkg::*; #(
	parameter int DEPTH = QUEUE_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// host bus, address from pins or address latch
	input wire logic [ADDR_W-1:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [DATA_W-1:0] host_wdata,
	output logic [DATA_W-1:0] host_rdata_q,
	output logic host_rvalid_q,
	// command engine
	output logic [CMD_W-1:0] cmd_code_q,
	output logic cmd_start_q,
	input wire logic cmd_done,
	input wire logic probe_done,
	// core side of the data queue
	input wire logic core_push,
	input wire logic [DATA_W-1:0] core_push_data,
	output logic core_push_lost_q,
	input wire logic core_pop,
	output logic [DATA_W-1:0] core_pop_data_q,
	output logic core_pop_valid_q,
	output logic [$clog2(DEPTH):0] queue_level_q,
	// status sources
	input wire logic irq_flag,
	input wire logic err_flag,
	input wire logic [MODEM_W-1:0] radio_modem_phase,
	input wire logic [MARGIN_W-1:0] queue_warning_margin,
	// paging state
	output logic page_override_enable_q,
	output logic [PAGE_W-1:0] page_number_q
);
	localparam int LW = $clog2(DEPTH) + 1;

	initial begin
		if (DEPTH <= (1 << MARGIN_W))
			$error("queue depth must exceed the warning margin range");
	end

	function automatic logic is_reg(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs);
		is_reg = a == ofs;
	endfunction

	logic probe_pending_q;
	logic [DATA_W-1:0] status_q;

	// address formation
	wire [ADDR_W-1:0] eff_addr = page_override_enable_q ?
		{page_number_q, host_addr[2:0]} : host_addr;

	wire sel_page = eff_addr[2:0] == PAGE_LOW_OFS;
	wire sel_cmd = is_reg(eff_addr, CMD_OFS);
	wire sel_queue = is_reg(eff_addr, QUEUE_OFS);
	wire sel_status = is_reg(eff_addr, STATUS_OFS);

	wire wr_page = host_wr && sel_page;
	wire wr_cmd = host_wr && sel_cmd;
	wire wr_queue = host_wr && sel_queue;
	wire rd_queue = host_rd && sel_queue;

	// queue: host wins both the fill port and the read port
	wire [LW-1:0] q_level;
	wire q_full;
	wire q_empty;
	wire [DATA_W-1:0] q_head;
	wire q_push = wr_queue || core_push;
	wire [DATA_W-1:0] q_push_data = wr_queue ? host_wdata : core_push_data;
	wire q_pop = rd_queue || core_pop;
	wire core_pop_ok = core_pop && !rd_queue && !q_empty;

	pcfr_queue #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH)
	) u_queue (
		.clk(clk),
		.srst(srst),
		.push(q_push),
		.push_data(q_push_data),
		.pop(q_pop),
		.head(q_head),
		.level(q_level),
		.full(q_full),
		.empty(q_empty)
	);

	// warnings from the margin, using the level before this cycle's push or pop
	wire [LW-1:0] margin_ext = LW'(queue_warning_margin);
	wire [LW-1:0] free_slots = LW'(DEPTH) - q_level;
	wire nearly_full = free_slots <= margin_ext;
	wire nearly_empty = q_level <= margin_ext;

	wire [DATA_W-1:0] status_d = {1'b0, irq_flag, err_flag,
		radio_modem_phase, nearly_full, nearly_empty};

	wire [DATA_W-1:0] page_rd = {page_override_enable_q, 4'h0,
		page_number_q};
	wire [DATA_W-1:0] cmd_rd = {probe_pending_q, 1'b0, cmd_code_q};

	// read mux; unmapped addresses read as zero
	wire [DATA_W-1:0] rd_mux = sel_page ? page_rd :
		sel_cmd ? cmd_rd :
		sel_queue ? (q_empty ? '0 : q_head) :
		sel_status ? status_q : '0;

	always_ff @(posedge clk) begin
		if (srst) begin
			page_override_enable_q <= PAGE_RESET[PG_EN_BIT];
			page_number_q <= PAGE_RESET[PAGE_W-1:0];
		end else if (wr_page) begin
			// reserved bits are not stored, so they always read zero
			page_override_enable_q <= host_wdata[PG_EN_BIT];
			page_number_q <= host_wdata[PAGE_W-1:0];
		end
	end

	// host write beats a completion in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_code_q <= CMD_IDLE;
			cmd_start_q <= 1'b0;
		end else begin
			cmd_start_q <= wr_cmd;
			if (wr_cmd)
				cmd_code_q <= host_wdata[CMD_W-1:0];
			else if (cmd_done)
				cmd_code_q <= CMD_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			probe_pending_q <= 1'b1;
		else if (probe_done)
			probe_pending_q <= 1'b0;
	end

	// status has no write path at all
	always_ff @(posedge clk) begin
		if (srst)
			status_q <= STATUS_RESET;
		else
			status_q <= status_d;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			host_rdata_q <= '0;
			host_rvalid_q <= 1'b0;
		end else begin
			host_rvalid_q <= host_rd;
			if (host_rd)
				host_rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			core_pop_data_q <= '0;
			core_pop_valid_q <= 1'b0;
			core_push_lost_q <= 1'b0;
			queue_level_q <= '0;
		end else begin
			core_pop_valid_q <= core_pop_ok;
			if (core_pop_ok)
				core_pop_data_q <= q_head;
			// a core byte colliding with a host queue write is dropped
			core_push_lost_q <= core_push && (wr_queue || q_full);
			queue_level_q <= q_level;
		end
	end
endmodule

// ===== src/pcfr_pkg.sv
package pcfr_pkg;
	// host address and register layout
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int PAGE_W = 3;
	localparam int CMD_W = 6;
	localparam logic [2:0] PAGE_LOW_OFS = 3'h0;
	localparam logic [5:0] CMD_OFS = 6'h01;
	localparam logic [5:0] QUEUE_OFS = 6'h02;
	localparam logic [5:0] STATUS_OFS = 6'h03;
	// page-selection fields
	localparam int PG_EN_BIT = 7;
	localparam logic [7:0] PAGE_RESET = 8'h80;
	// command register fields
	localparam int PROBE_BIT = 7;
	localparam logic [5:0] CMD_IDLE = 6'h00;
	// status register fields
	localparam int ST_IRQ_BIT = 6;
	localparam int ST_ERR_BIT = 5;
	localparam int ST_MODEM_LSB = 2;
	localparam int MODEM_W = 3;
	localparam int ST_HI_BIT = 1;
	localparam int ST_LO_BIT = 0;
	localparam logic [7:0] STATUS_RESET = 8'h01;
	// data queue
	localparam int QUEUE_DEPTH = 64;
	localparam int MARGIN_W = 4;
endpackage

// ===== src/pcfr_queue.sv
`timescale 1ns/10ps
module pcfr_queue import pcfr_pkg::*; #(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = QUEUE_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// fill side
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	// drain side
	input wire logic pop,
	output logic [WIDTH-1:0] head,
	// state
	output logic [$clog2(DEPTH):0] level,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("queue depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [AW:0] count_q;
	wire do_push = push && !full;
	wire do_pop = pop && !empty;

	assign full = count_q == (AW+1)'(DEPTH);
	assign empty = count_q == '0;
	assign level = count_q;
	assign head = mem[rptr_q];

	always_ff @(posedge clk) begin
		if (do_push)
			mem[wptr_q] <= push_data;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
		end else begin
			if (do_push)
				wptr_q <= wptr_q + 1'b1;
			if (do_pop)
				rptr_q <= rptr_q + 1'b1;
			if (do_push && !do_pop)
				count_q <= count_q + 1'b1;
			else if (do_pop && !do_push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule

// ===== test/pcfr_regs_asserts.sv
`timescale 1ns/10ps
module pcfr_regs_asserts import pcfr_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// host bus
	input wire logic [ADDR_W-1:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [DATA_W-1:0] host_wdata,
	input wire logic [DATA_W-1:0] host_rdata_q,
	input wire logic host_rvalid_q,
	// command and paging
	input wire logic [CMD_W-1:0] cmd_code_q,
	input wire logic cmd_start_q,
	input wire logic cmd_done,
	input wire logic page_override_enable_q,
	input wire logic [PAGE_W-1:0] page_number_q
);
	// effective address as the host sees it
	wire logic [ADDR_W-1:0] eff = page_override_enable_q ?
		{page_number_q, host_addr[2:0]} : host_addr;
	default clocking @(posedge clk); endclocking
	default disable iff srst;
	a_rd_answer: assert property (host_rd |=> host_rvalid_q)
		else $error("read not answered");
	a_no_answer: assert property (!host_rd |=> !host_rvalid_q)
		else $error("stray read answer");
	a_cmd_start: assert property (host_wr && eff == CMD_OFS |=>
		cmd_start_q && cmd_code_q == $past(host_wdata[CMD_W-1:0]))
		else $error("command write not started");
	a_start_cause: assert property (cmd_start_q |-> $past(host_wr))
		else $error("start without write");
	a_cmd_hold: assert property (!host_wr && !cmd_done |=>
		$stable(cmd_code_q)) else $error("command code drifted");
	a_done_idle: assert property (cmd_done && !host_wr |=>
		cmd_code_q == CMD_IDLE) else $error("completion not seen");
	a_page_wr: assert property (host_wr && eff[2:0] == 3'h0 |=>
		page_override_enable_q == $past(host_wdata[7]) &&
		page_number_q == $past(host_wdata[2:0]))
		else $error("page write lost");
	a_page_rd: assert property (host_rd && eff[2:0] == 3'h0 |=>
		host_rdata_q == {$past(page_override_enable_q), 4'h0,
		$past(page_number_q)}) else $error("page read wrong");
endmodule
bind pcfr_regs pcfr_regs_asserts i_chk (.*);

// ===== test/pcfr_engine_model.sv
`timescale 1ns/10ps
module pcfr_engine_model #(
	parameter int RUN = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// command engine
	input wire logic cmd_start,
	output logic cmd_done,
	output logic probe_done
);
	int run_q;
	int boot_q;
	// probe finishes a fixed while after each reset
	assign probe_done = boot_q >= 16;
	assign cmd_done = run_q == 1;
	always_ff @(posedge clk) begin
		boot_q <= srst ? 0 : boot_q + int'(boot_q < 16);
		run_q <= srst ? 0 : cmd_start ? RUN : run_q - int'(run_q != 0);
	end
endmodule

// ===== test/page_command_fifo_regs_bench.sv
`timescale 1ns/10ps
module page_command_fifo_regs_bench import pcfr_pkg::*;;
	logic clk = 1'h0, srst = 1'h1, host_wr = 1'h0, host_rd = 1'h0;
	logic core_push = 1'h0, core_pop = 1'h0, irq_flag = 1'h1, err_flag = 1'h0;
	logic [5:0] host_addr = 6'h0;
	logic [7:0] host_wdata = 8'h0, core_push_data = 8'h77;
	logic [2:0] radio_modem_phase = 3'h5;
	logic [3:0] queue_warning_margin = 4'h3;
	logic [7:0] host_rdata_q, core_pop_data_q;
	logic [5:0] cmd_code_q;
	logic [6:0] queue_level_q;
	logic [2:0] page_number_q;
	logic host_rvalid_q, cmd_start_q, cmd_done, probe_done, core_push_lost_q;
	logic core_pop_valid_q, page_override_enable_q;
	int error_cnt = 0, checks_done = 0;
	// address, write data, read-back
	logic [21:0] rows [9] = '{{6'h01, 8'h0a, 8'h0a}, {6'h01, 8'hff, 8'h3f},
		{6'h00, 8'h7d, 8'h05}, {6'h2b, 8'h55, 8'h00}, {6'h28, 8'h82, 8'h82},
		{6'h08, 8'h80, 8'h80}, {6'h03, 8'hff, 8'h55}, {6'h02, 8'h3c, 8'h3c},
		{6'h0a, 8'h11, 8'h11}};
	pcfr_regs i_dut (.*);
	pcfr_engine_model i_eng (.clk, .srst, .cmd_start(cmd_start_q), .cmd_done,
		.probe_done);
	always #2.5 clk = ~clk;
	task automatic end_sim;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("wrong value %s exp %h got %h", name, exp, got);
			error_cnt++;
		end
	endtask
	task automatic hw(logic [5:0] a, logic [7:0] d);
		{host_wr, host_addr, host_wdata} = {1'h1, a, d};
		@(negedge clk);
		host_wr = 1'h0;
	endtask
	task automatic hr(logic [5:0] a, logic [7:0] e);
		{host_rd, host_addr} = {1'h1, a};
		@(negedge clk);
		// rvalid stands one cycle only, so look before it drops
		chk("rvalid", 8'h01, {7'h0, host_rvalid_q});
		chk("rdata", e, host_rdata_q);
		host_rd = 1'h0;
		@(negedge clk);
	endtask
	task automatic rst;
		srst = 1'h1;
		repeat (5) @(negedge clk);
		srst = 1'h0;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		error_cnt++;
		end_sim;
	end
	initial begin
		rst;
		repeat (20) @(negedge clk);
		foreach (rows[i]) begin
			hw(rows[i][21:16], rows[i][15:8]);
			hr(rows[i][21:16], rows[i][7:0]);
		end
		hw(6'h01, 8'h0c);
		chk("cmd_start", 8'h01, {7'h0, cmd_start_q});
		repeat (12) @(negedge clk);
		hr(6'h01, 8'h00);
		hw(6'h02, 8'h5a);
		core_pop = 1'h1;
		@(negedge clk);
		chk("pop_valid", 8'h01, {7'h0, core_pop_valid_q});
		chk("pop_data", 8'h5a, core_pop_data_q);
		core_pop = 1'h0;
		@(negedge clk);
		// core byte colliding with a host queue write is dropped
		core_push = 1'h1;
		hw(6'h02, 8'h33);
		chk("push_lost", 8'h01, {7'h0, core_push_lost_q});
		core_push = 1'h0;
		@(negedge clk);
		chk("level", 8'h01, {1'h0, queue_level_q});
		rst;
		hr(6'h03, STATUS_RESET);
		hr(6'h00, PAGE_RESET);
		hr(6'h01, 8'h80);
		end_sim;
	end
endmodule
